// *** hdl/lmp_pkg.sv ***
// Purpose: shared constants and types of the ladder math and pwm unit
// Assumes: 25 MHz system clock
// Notes: the 1 ms tick count is exposed as a top-level parameter
package lmp_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TICK_SHORT_US = 100;
    localparam int unsigned TICK_LONG_US = 1000;
    localparam int unsigned TICK_SHORT_CYC = TICK_SHORT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned TICK_LONG_CYC = TICK_LONG_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PWM_CNT_W = 15;
    localparam logic [14:0] PWM_CNT_MIN = 15'h0001;
    localparam logic [14:0] PWM_CNT_MAX = 15'h7FFF;
    localparam logic [31:0] FP_ZERO_KEY = 32'h8000_0000;
    localparam logic [7:0] FP_EXP_MAX = 8'hFF;

    typedef enum logic [2:0] {
        OP_PWM = 3'b000,
        OP_ABS = 3'b001,
        OP_POW = 3'b010,
        OP_FCMP = 3'b011,
        OP_FZCP = 3'b100,
        OP_FADD = 3'b101,
        OP_FSUB = 3'b110
    } lmp_op_t;

    typedef enum logic [1:0] {
        RK_WORD = 2'b00,
        RK_DWORD = 2'b01,
        RK_BITS = 2'b10
    } lmp_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POW = 2'b01
    } lmp_state_t;
endpackage

// *** hdl/lmp_pwm_chan.sv ***
// Purpose: one pwm channel counting shared sampling ticks
// Assumes: tick_i is a one-cycle enable pulse
// Notes: width above period simply holds the output high
module lmp_pwm_chan
    import lmp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic [14:0] width_i,
    input wire logic [14:0] period_i,
    output logic pwm_o
);
    logic [14:0] cnt;
    logic run_q;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_i;
        end
    end

    // restart the period whenever the channel is (re)enabled
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 15'h0000;
        end else if (run_i && !run_q) begin
            cnt <= 15'h0000;
        end else if (run_i && tick_i) begin
            if ({1'b0, cnt} + 16'h0001 >= {1'b0, period_i}) begin
                cnt <= 15'h0000;
            end else begin
                cnt <= cnt + 15'h0001;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= run_i && (cnt < width_i);
        end
    end
endmodule // lmp_pwm_chan

// *** hdl/lmp_unit.sv ***
// Purpose: execution datapath for pwm, abs, pow and float compare/zone/add/sub
// Assumes: sequencer presents one instruction per scan step with its condition
// Notes: float operands are raw 32-bit patterns; add and subtract flush denormals to zero
//
// Operation
// - pwm width and period are tick counts, each 1 through 32767.
// - one sampling tick, 100 us or 1 ms, shared by both pwm channels.
// - pwm drives only one of exactly two dedicated outputs.
// - pwm runs only while its input condition stays active.
// - abs negates a negative operand in place; positive stays unchanged.
// - pow raises signed first source to signed second source power.
// - float operations are 32-bit only, two words per operand.
// - immediate float operands are used as raw bit patterns, unconverted.
// - compare sets bit0 if s2<s1, bit1 if equal, bit2 if s2>s1.
// - compare result bits hold after the condition drops.
// - zone compare: bit0 below, bit1 within, bit2 above the bounds.
// - zone lower bound above upper bound clears all three bits.
// - zone result bits hold after the condition drops.
// - float add sums both sources into the destination pair.
// - destination may equal a source; accumulation repeats every scan.
// - float subtract computes first minus second source.
module lmp_unit
    import lmp_pkg::*;
#(
    parameter int unsigned INT_W = 16,
    parameter int unsigned TICK_LONG_CYCLES = TICK_LONG_CYC
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic instr_valid_i,
    input wire logic [2:0] opcode_i,
    input wire logic cond_i,
    input wire logic [31:0] first_source_operand_i,
    input wire logic [31:0] second_source_operand_i,
    input wire logic [31:0] test_operand_i,
    input wire logic [15:0] dst_addr_i,
    input wire logic pwm_chan_i,
    input wire logic pwm_sample_period_select_i,
    output logic ready_o,
    output logic res_valid_o,
    output logic [1:0] res_kind_o,
    output logic [15:0] res_addr_o,
    output logic [31:0] res_data_o,
    output logic pwm_output_a_o,
    output logic pwm_output_b_o
);
    generate
        if (INT_W != 16 && INT_W != 32) begin : g_bad_w
            $error("INT_W must be 16 or 32");
        end
        if (TICK_LONG_CYCLES < 2 || TICK_LONG_CYCLES > 32'h00FF_FFFF) begin : g_bad_t
            $error("TICK_LONG_CYCLES out of range");
        end
    endgenerate

    // order key: unsigned compare of keys matches float order, +0 equals -0
    function automatic logic [31:0] fp_key(input logic [31:0] a);
        if (a[30:0] == 31'h0) begin
            return FP_ZERO_KEY;
        end
        return a[31] ? ~a : {1'b1, a[30:0]};
    endfunction

    // single precision add, round to nearest even, denormals flushed
    function automatic logic [31:0] fp_add(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] x;
        logic [31:0] y;
        logic [7:0] d;
        logic [26:0] mx;
        logic [26:0] my;
        logic [53:0] sh;
        logic [27:0] s;
        logic [8:0] e;
        logic [24:0] m;
        logic rnd;
        x = (a[30:0] >= b[30:0]) ? a : b;
        y = (a[30:0] >= b[30:0]) ? b : a;
        if (x[30:23] == FP_EXP_MAX) begin
            return x;
        end
        if (x[30:23] == 8'h00) begin
            return {x[31] & y[31], 31'h0};
        end
        if (y[30:23] == 8'h00) begin
            return x;
        end
        d = x[30:23] - y[30:23];
        mx = {1'b1, x[22:0], 3'b000};
        my = {1'b1, y[22:0], 3'b000};
        sh = {my, 27'h0} >> ((d > 8'd27) ? 8'd27 : d);
        my = sh[53:27] | {26'h0, |sh[26:0]};
        s = (x[31] == y[31]) ? ({1'b0, mx} + {1'b0, my}) : ({1'b0, mx} - {1'b0, my});
        if (s == 28'h0) begin
            return 32'h0000_0000;
        end
        e = {1'b0, x[30:23]};
        if (s[27]) begin
            s = {1'b0, s[27:2], s[1] | s[0]};
            e = e + 9'h001;
        end
        for (int i = 0; i < 26; i++) begin
            if (!s[26] && e > 9'h001) begin
                s = {s[26:0], 1'b0};
                e = e - 9'h001;
            end
        end
        if (!s[26]) begin
            return {x[31], 31'h0};
        end
        rnd = s[2] & (s[1] | s[0] | s[3]);
        m = {1'b0, s[26:3]} + {24'h0, rnd};
        if (m[24]) begin
            m = {1'b0, m[24:1]};
            e = e + 9'h001;
        end
        if (e >= {1'b0, FP_EXP_MAX}) begin
            return {x[31], FP_EXP_MAX, 23'h0};
        end
        return {x[31], e[7:0], m[22:0]};
    endfunction

    lmp_state_t state;
    logic [INT_W-1:0] pow_res;
    logic [INT_W-1:0] pow_base;
    logic [INT_W-1:0] pow_exp;
    logic [15:0] pow_addr;
    logic [INT_W-1:0] s1_int;
    logic [INT_W-1:0] s2_int;
    logic take;
    logic [31:0] key1;
    logic [31:0] key2;
    logic [31:0] keyt;
    logic [31:0] next_sum;
    logic [1:0] int_kind;
    logic [23:0] tick_cnt;
    logic [23:0] tick_lim;
    logic tick;
    logic [1:0] pwm_run;
    logic [14:0] pwm_width [2];
    logic [14:0] pwm_period [2];
    logic [1:0] pwm_out;
    logic pwm_ok;

    assign ready_o = (state == ST_IDLE);
    assign take = instr_valid_i && ready_o;
    assign s1_int = first_source_operand_i[INT_W-1:0];
    assign s2_int = second_source_operand_i[INT_W-1:0];
    assign int_kind = (INT_W == 32) ? RK_DWORD : RK_WORD;
    // raw patterns, never converted from integer form
    assign key1 = fp_key(first_source_operand_i);
    assign key2 = fp_key(second_source_operand_i);
    assign keyt = fp_key(test_operand_i);
    // subtract reuses the adder with the second sign flipped
    assign next_sum = fp_add(first_source_operand_i,
        {second_source_operand_i[31] ^ (opcode_i == OP_FSUB),
         second_source_operand_i[30:0]});
    assign pwm_ok = first_source_operand_i[31:15] == 17'h0
        && second_source_operand_i[31:15] == 17'h0
        && first_source_operand_i[14:0] >= PWM_CNT_MIN
        && second_source_operand_i[14:0] >= PWM_CNT_MIN;

    // shared sampling tick; counter restarts at the shorter limit if it overshoots
    assign tick_lim = pwm_sample_period_select_i ? 24'(TICK_LONG_CYCLES)
        : 24'(TICK_SHORT_CYC);
    assign tick = (tick_cnt >= tick_lim - 24'h000001);

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_cnt <= 24'h000000;
        end else if (tick) begin
            tick_cnt <= 24'h000000;
        end else begin
            tick_cnt <= tick_cnt + 24'h000001;
        end
    end

    // pwm state is loaded every scan; out-of-range counts are ignored
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pwm_run <= 2'b00;
            pwm_width[0] <= PWM_CNT_MIN;
            pwm_width[1] <= PWM_CNT_MIN;
            pwm_period[0] <= PWM_CNT_MIN;
            pwm_period[1] <= PWM_CNT_MIN;
        end else if (take && opcode_i == OP_PWM) begin
            if (!cond_i) begin
                pwm_run[pwm_chan_i] <= 1'b0;
            end else if (pwm_ok) begin
                pwm_run[pwm_chan_i] <= 1'b1;
                pwm_width[pwm_chan_i] <= first_source_operand_i[14:0];
                pwm_period[pwm_chan_i] <= second_source_operand_i[14:0];
            end
        end
    end

    generate
        for (genvar c = 0; c < 2; c++) begin : g_pwm
            lmp_pwm_chan u_chan (
                .mclk_i(mclk_i),
                .sys_rst_i(sys_rst_i),
                .tick_i(tick),
                .run_i(pwm_run[c]),
                .width_i(pwm_width[c]),
                .period_i(pwm_period[c]),
                .pwm_o(pwm_out[c])
            );
        end
    endgenerate

    assign pwm_output_a_o = pwm_out[0];
    assign pwm_output_b_o = pwm_out[1];

    // pow: square-and-multiply, one exponent bit per cycle
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
            pow_res <= '0;
            pow_base <= '0;
            pow_exp <= '0;
            pow_addr <= 16'h0000;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (take && cond_i && opcode_i == OP_POW && !s2_int[INT_W-1]) begin
                        state <= ST_POW;
                        pow_res <= INT_W'(1);
                        pow_base <= s1_int;
                        pow_exp <= s2_int;
                        pow_addr <= dst_addr_i;
                    end
                end
                ST_POW: begin
                    if (pow_exp == '0) begin
                        state <= ST_IDLE;
                    end else begin
                        if (pow_exp[0]) begin
                            pow_res <= INT_W'(pow_res * pow_base);
                        end
                        pow_base <= INT_W'(pow_base * pow_base);
                        pow_exp <= pow_exp >> 1;
                    end
                end
            endcase
        end
    end

    // one result per accepted abs, pow or float instruction; condition low writes nothing
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            res_valid_o <= 1'b0;
            res_kind_o <= RK_WORD;
            res_addr_o <= 16'h0000;
            res_data_o <= 32'h0000_0000;
        end else begin
            res_valid_o <= 1'b0;
            if (state == ST_POW && pow_exp == '0) begin
                res_valid_o <= 1'b1;
                res_kind_o <= int_kind;
                res_addr_o <= pow_addr;
                res_data_o <= 32'(signed'(pow_res));
            end else if (take && cond_i) begin
                res_addr_o <= dst_addr_i;
                unique case (opcode_i)
                    OP_ABS: begin
                        res_valid_o <= 1'b1;
                        res_kind_o <= int_kind;
                        res_data_o <= 32'(signed'(s1_int[INT_W-1] ? -s1_int : s1_int));
                    end
                    OP_POW: begin
                        // negative exponent: only a base of +1 or -1 survives
                        if (s2_int[INT_W-1]) begin
                            res_valid_o <= 1'b1;
                            res_kind_o <= int_kind;
                            if (s1_int == INT_W'(1)) begin
                                res_data_o <= 32'h0000_0001;
                            end else if (s1_int == '1) begin
                                res_data_o <= s2_int[0] ? 32'hFFFF_FFFF : 32'h0000_0001;
                            end else begin
                                res_data_o <= 32'h0000_0000;
                            end
                        end
                    end
                    OP_FCMP: begin
                        res_valid_o <= 1'b1;
                        res_kind_o <= RK_BITS;
                        res_data_o <= {29'h0, key2 > key1, key2 == key1, key2 < key1};
                    end
                    OP_FZCP: begin
                        res_valid_o <= 1'b1;
                        res_kind_o <= RK_BITS;
                        if (key1 > key2) begin
                            res_data_o <= 32'h0000_0000;
                        end else begin
                            res_data_o <= {29'h0, keyt > key2,
                                keyt >= key1 && keyt <= key2, keyt < key1};
                        end
                    end
                    OP_FADD, OP_FSUB: begin
                        res_valid_o <= 1'b1;
                        res_kind_o <= RK_DWORD;
                        res_data_o <= next_sum;
                    end
                    default: begin
                        res_valid_o <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // lmp_unit

// *** testbench/lmp_seq_model.sv ***
// Purpose: scan sequencer model presenting one instruction per step
// Assumes: drives on the falling edge, holds until the take edge
// Notes: released operands show inverted data so a stale value never looks valid
module lmp_seq_model
    import lmp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rdy_i,
    output logic valid_o,
    output logic [2:0] op_o,
    output logic cond_o,
    output logic [31:0] s1_o,
    output logic [31:0] s2_o,
    output logic [31:0] st_o,
    output logic [15:0] dst_o,
    output logic chan_o,
    output logic sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {valid_o, op_o, cond_o, chan_o, sel_o} = '0;
        {s1_o, s2_o, st_o} = '0;
        dst_o = 16'h0100;
    end
    task automatic issue(input logic [2:0] op, input logic c, input logic [31:0] a,
        input logic [31:0] b, input logic [31:0] t, input logic ch, output logic [15:0] ad);
        @(negedge mclk_i);
        valid_o = 1'b1;
        op_o = op;
        cond_o = c;
        s1_o = a;
        s2_o = b;
        st_o = t;
        chan_o = ch;
        dst_o = dst_o + 16'h0003;
        ad = dst_o;
        while (rdy_i !== 1'b1) @(negedge mclk_i);
        @(negedge mclk_i);
        valid_o = 1'b0;
        {s1_o, s2_o, st_o} = ~{s1_o, s2_o, st_o};
    endtask
    task automatic pwm_run(input logic ch, input logic c, input logic [31:0] w,
        input logic [31:0] p);
        logic [15:0] ad;
        issue(OP_PWM, c, w, (w > p) ? w : p, 32'h0, ch, ad);
    endtask
endmodule // lmp_seq_model

// *** testbench/lmp_unit_assertions.sv ***
// Purpose: port checks of the ladder math and pwm unit
// Assumes: one clock, async active-high reset
// Notes: zone order check uses non-negative bounds so raw bits order like floats
module lmp_chk
    import lmp_pkg::*;
#(
    parameter int unsigned INT_W = 16,
    parameter int unsigned TICK_LONG_CYCLES = 25000
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic instr_valid_i,
    input wire logic [2:0] opcode_i,
    input wire logic cond_i,
    input wire logic [31:0] first_source_operand_i,
    input wire logic [31:0] second_source_operand_i,
    input wire logic [15:0] dst_addr_i,
    input wire logic pwm_chan_i,
    input wire logic ready_o,
    input wire logic res_valid_o,
    input wire logic [1:0] res_kind_o,
    input wire logic [15:0] res_addr_o,
    input wire logic [31:0] res_data_o,
    input wire logic pwm_output_a_o,
    input wire logic pwm_output_b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    logic go;
    assign go = instr_valid_i && ready_o;
    sequence s_take(logic [2:0] op);
        go && cond_i && opcode_i == op;
    endsequence
    sequence s_pow_busy;
        !ready_o [*3] ##1 (ready_o && res_valid_o);
    endsequence
    AST_CMP_ONEHOT: assert property (s_take(OP_FCMP) |=> res_valid_o
        && res_kind_o == RK_BITS && $onehot(res_data_o[2:0]) && res_addr_o == $past(dst_addr_i))
        else $error("compare result not one hot");
    AST_CMP_EQUAL: assert property ((s_take(OP_FCMP)
        and (first_source_operand_i == second_source_operand_i)) |=> res_data_o[2:0] == 3'b010)
        else $error("equal compare wrong bit");
    AST_ZONE_SWAP: assert property ((s_take(OP_FZCP) and (!first_source_operand_i[31]
        && !second_source_operand_i[31] && first_source_operand_i > second_source_operand_i))
        |=> res_valid_o && res_data_o[2:0] == 3'b000) else $error("swapped zone not cleared");
    AST_NO_WRITE_COND: assert property (go && !cond_i |=> !res_valid_o)
        else $error("write with condition low");
    AST_PWM_SILENT: assert property (go && opcode_i == OP_PWM |=> !res_valid_o)
        else $error("pwm wrote a result");
    AST_PWM_STOP: assert property (go && !cond_i && opcode_i == OP_PWM
        |-> ##2 ($past(pwm_chan_i, 2) ? !pwm_output_b_o : !pwm_output_a_o))
        else $error("pwm still running after stop");
    AST_FLOAT_PAIR: assert property (go && cond_i
        && (opcode_i == OP_FADD || opcode_i == OP_FSUB) |=> res_valid_o && res_kind_o == RK_DWORD)
        else $error("float result not a word pair");
    AST_ABS_KEEP: assert property ((s_take(OP_ABS)
        and !first_source_operand_i[INT_W-1])
        |=> res_kind_o == (INT_W == 32 ? RK_DWORD : RK_WORD)
        && res_data_o[INT_W-1:0] == $past(first_source_operand_i[INT_W-1:0]))
        else $error("positive abs changed");
    AST_POW_LAT: assert property ((s_take(OP_POW)
        and (second_source_operand_i[INT_W-1:0] == INT_W'(2))) |=> s_pow_busy)
        else $error("pow timing wrong");
endmodule // lmp_chk

bind lmp_unit lmp_chk #(.INT_W(INT_W), .TICK_LONG_CYCLES(TICK_LONG_CYCLES)) u_chk (
    .mclk_i, .sys_rst_i, .instr_valid_i, .opcode_i, .cond_i, .first_source_operand_i,
    .second_source_operand_i, .dst_addr_i, .pwm_chan_i, .ready_o, .res_valid_o, .res_kind_o,
    .res_addr_o, .res_data_o, .pwm_output_a_o, .pwm_output_b_o);

// *** testbench/tb.sv ***
// Purpose: self-checking bench of the ladder math and pwm unit
// Assumes: long tick shortened to 50 cycles
// Notes: table rows cover abs, pow and float ops; pwm and hold cases follow
module tb
    import lmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TL = 50;
    typedef struct {
        logic [2:0] op;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] t;
        logic [1:0] k;
        logic [31:0] d;
    } lmp_row_t;
    logic mclk_i, sys_rst_i, valid, cond, chan, sel, ready, rv, pa, pb;
    logic [2:0] op;
    logic [1:0] rk;
    logic [15:0] dst, ra, ad;
    logic [31:0] s1, s2, st, rd, acc, m;
    int miscompares, tests_run, n, hi, lo;
    lmp_row_t rows [20] = '{
        '{OP_ABS, 32'hFFFFFFFB, 32'h0, 32'h0, RK_WORD, 32'h5},
        '{OP_ABS, 32'h7, 32'h0, 32'h0, RK_WORD, 32'h7},
        '{OP_POW, 32'h3, 32'h2, 32'h0, RK_WORD, 32'h9},
        '{OP_POW, 32'hFFFFFFFE, 32'h3, 32'h0, RK_WORD, 32'hFFFFFFF8},
        '{OP_POW, 32'h5, 32'h0, 32'h0, RK_WORD, 32'h1},
        '{OP_POW, 32'h2, 32'hFFFFFFFF, 32'h0, RK_WORD, 32'h0},
        '{OP_POW, 32'hFFFFFFFF, 32'hFFFFFFFD, 32'h0, RK_WORD, 32'hFFFFFFFF},
        '{OP_FCMP, 32'h3F800000, 32'h40000000, 32'h0, RK_BITS, 32'h4},
        '{OP_FCMP, 32'h40000000, 32'h3F800000, 32'h0, RK_BITS, 32'h1},
        '{OP_FCMP, 32'h3F800000, 32'h3F800000, 32'h0, RK_BITS, 32'h2},
        '{OP_FCMP, 32'h0, 32'h80000000, 32'h0, RK_BITS, 32'h2},
        '{OP_FCMP, 32'hBF800000, 32'h3F800000, 32'h0, RK_BITS, 32'h4},
        '{OP_FZCP, 32'h3F800000, 32'h40400000, 32'h40000000, RK_BITS, 32'h2},
        '{OP_FZCP, 32'h3F800000, 32'h40400000, 32'h3F000000, RK_BITS, 32'h1},
        '{OP_FZCP, 32'h3F800000, 32'h40400000, 32'h40800000, RK_BITS, 32'h4},
        '{OP_FZCP, 32'h40400000, 32'h3F800000, 32'h40000000, RK_BITS, 32'h0},
        '{OP_FADD, 32'h3FC00000, 32'hBF000000, 32'h0, RK_DWORD, 32'h3F800000},
        '{OP_FADD, 32'h3F800000, 32'h1, 32'h0, RK_DWORD, 32'h3F800000},
        '{OP_FSUB, 32'h40000000, 32'h3F000000, 32'h0, RK_DWORD, 32'h3FC00000},
        '{OP_FSUB, 32'h3F800000, 32'h40000000, 32'h0, RK_DWORD, 32'hBF800000}};
    lmp_seq_model u_seq (.mclk_i(mclk_i), .rdy_i(ready), .valid_o(valid), .op_o(op),
        .cond_o(cond), .s1_o(s1), .s2_o(s2), .st_o(st), .dst_o(dst), .chan_o(chan), .sel_o(sel));
    lmp_unit #(.INT_W(16), .TICK_LONG_CYCLES(TL)) u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .instr_valid_i(valid), .opcode_i(op), .cond_i(cond), .first_source_operand_i(s1),
        .second_source_operand_i(s2), .test_operand_i(st), .dst_addr_i(dst), .pwm_chan_i(chan),
        .pwm_sample_period_select_i(sel), .ready_o(ready), .res_valid_o(rv), .res_kind_o(rk),
        .res_addr_o(ra), .res_data_o(rd), .pwm_output_a_o(pa), .pwm_output_b_o(pb));
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    task automatic wait_res();
        n = 0;
        while (rv !== 1'b1 && n < 40) begin
            @(negedge mclk_i);
            n++;
        end
        chk("res_valid", 32'h1, {31'h0, rv});
    endtask
    task automatic run_while(input logic ch, input logic lvl, input int lim, output int c);
        c = 0;
        while ((ch ? pb : pa) === lvl && c < lim) begin
            @(negedge mclk_i);
            c++;
        end
    endtask
    // skip two periods so the free-running divider phase cannot shorten the count
    task automatic meas(input logic ch);
        repeat (2) begin
            run_while(ch, 1'b1, 9000, n);
            run_while(ch, 1'b0, 9000, n);
        end
        run_while(ch, 1'b1, 9000, hi);
        run_while(ch, 1'b0, 9000, lo);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #(40 * 60000);
        miscompares++;
        wrap_up();
    end
    initial begin
        sys_rst_i = 1'b1;
        repeat (5) @(posedge mclk_i);
        @(negedge mclk_i);
        sys_rst_i = 1'b0;
        chk("ready", 32'h1, {31'h0, ready});
        chk("idle", 32'h0, {30'h0, pa, pb});
        $display("test reset done");
        foreach (rows[i]) begin
            u_seq.issue(rows[i].op, 1'b1, rows[i].a, rows[i].b, rows[i].t, 1'b0, ad);
            wait_res();
            m = (rows[i].k == RK_BITS) ? 32'h7 : 32'hFFFFFFFF;
            chk("kind", {30'h0, rows[i].k}, {30'h0, rk});
            chk("data", rows[i].d, rd & m);
            chk("addr", {16'h0, ad}, {16'h0, ra});
        end
        $display("test table done");
        acc = 32'h3F800000;
        repeat (3) begin
            u_seq.issue(OP_FADD, 1'b1, acc, 32'h3F800000, 32'h0, 1'b0, ad);
            wait_res();
            acc = rd;
        end
        chk("accumulate", 32'h40800000, acc);
        u_seq.issue(OP_FCMP, 1'b0, 32'h0, 32'h3F800000, 32'h0, 1'b0, ad);
        chk("no write", 32'h0, {31'h0, rv});
        u_seq.issue(OP_FZCP, 1'b0, 32'h0, 32'h3F800000, 32'h0, 1'b0, ad);
        chk("no write", 32'h0, {31'h0, rv});
        chk("data kept", 32'h40800000, rd);
        $display("test hold done");
        u_seq.sel_o = 1'b1;
        u_seq.pwm_run(1'b0, 1'b1, 32'h3, 32'h8);
        meas(1'b0);
        chk("long high", 32'(3 * TL), hi);
        chk("long low", 32'(5 * TL), lo);
        chk("b idle", 32'h0, {31'h0, pb});
        u_seq.issue(OP_PWM, 1'b1, 32'h0, 32'h8, 32'h0, 1'b0, ad);
        meas(1'b0);
        chk("kept high", 32'(3 * TL), hi);
        u_seq.pwm_run(1'b0, 1'b0, 32'h3, 32'h8);
        repeat (3) @(negedge mclk_i);
        run_while(1'b0, 1'b0, 600, n);
        chk("stopped", 32'd600, n);
        u_seq.sel_o = 1'b0;
        u_seq.pwm_run(1'b1, 1'b1, 32'h1, 32'h2);
        meas(1'b1);
        chk("short high", 32'(TICK_SHORT_CYC), hi);
        chk("a idle", 32'h0, {31'h0, pa});
        u_seq.pwm_run(1'b1, 1'b0, 32'h1, 32'h2);
        $display("test pwm done");
        wrap_up();
    end
endmodule // tb
